// ---- rtl/fpsi_defs.vh ----
// Constants for the floating-point store and system instruction executor
// Behaviour
// RL1: Stack load reads a run of consecutive extension registers from the stack.
// RL2: Stack store writes a run of consecutive extension registers onto the stack.
// RL3: Software gives stack load and store lists of one to sixteen registers.
// RL4: An explicit size qualifier must equal the list register width, 32 or 64.
// RL5: Transfer lists are consecutive registers, all single-word or all double-word.
// RL6: Square root writes the root of the source into the destination.
// RL7: Ascending_after, the default, stores at consecutive addresses from the base.
// RL8: Descending_before stores at consecutive addresses ending just below the base.
// RL9: Writeback updates the base; descending_before requires writeback.
// RL10: Multi store needs one register at least, double-word lists at most 16.
// RL11: Single store address is base plus signed offset, multiple of 4, 0-1020.
// RL12: Single store writes one single or double extension register to memory.
// RL13: Subtract writes first operand minus second into the destination.
// RL14: Stack pointer is allowed as base; program counter as base is deprecated.
// RL15: Breakpoint trap moves the processor into debug state.
// RL16: Breakpoint immediate is 8 bits and ignored, kept only for a debugger.
// RL17: Breakpoint inside a predicated group executes unconditionally.
// RL18: Breakpoint leaves the condition flags unchanged.
// RL19: State change clears mask bits in clear form, sets them in set form.
// RL20: Selectors pick priority mask and fault mask bits, one or both.
// RL21: Immediate 0xab on breakpoint is reserved for semihosting use.
// RL22: Conditional floating-point and store operations execute only if condition holds.
// RL23: State change does nothing when unprivileged and ignores predication.
// RL24: Priority mask blocks configurable faults; fault mask blocks all faults.
// RL25: Stack load raises SP by list bytes; stack store lowers it.
`ifndef FPSI_DEFS_VH
`define FPSI_DEFS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define FPSI_OP_NONE 4'h0
`define FPSI_OP_STACK_LOAD 4'h1
`define FPSI_OP_STACK_STORE 4'h2
`define FPSI_OP_MULTI_STORE 4'h3
`define FPSI_OP_SINGLE_STORE 4'h4
`define FPSI_OP_SQUARE_ROOT 4'h5
`define FPSI_OP_SUBTRACT 4'h6
`define FPSI_OP_BREAKPOINT 4'h7
`define FPSI_OP_STATE_CHANGE 4'h8

// ----------------------------------------
// Sizes and limits
// ----------------------------------------
`define FPSI_WORD_BYTES 32'h4
`define FPSI_MAX_LIST 5'h10
`define FPSI_MAX_OFFSET 10'h3fc
`define FPSI_SP_INDEX 4'hd
`define FPSI_PC_INDEX 4'hf
`define FPSI_SEMIHOST_IMM 8'hab
`define FPSI_SIZE_SINGLE 7'h20
`define FPSI_SIZE_DOUBLE 7'h40

// ----------------------------------------
// Error codes
// ----------------------------------------
`define FPSI_ERR_NONE 3'h0
`define FPSI_ERR_LIST 3'h1
`define FPSI_ERR_SIZE 3'h2
`define FPSI_ERR_WBACK 3'h3
`define FPSI_ERR_OFFSET 3'h4

`endif

// ---- rtl/fpsi_fp_arith.v ----
// Square root and subtract unit on single-precision operands
`timescale 1ns/1ps
module fpsi_fp_arith (
	// Clock and reset
	input wire clock_in,
	input wire rstn_in,
	// Request
	input wire start_in,
	input wire is_sqrt_in,
	input wire [31:0] op_a_in,
	input wire [31:0] op_b_in,
	// Result
	output reg done_out,
	output reg [31:0] result_out
);
`include "fpsi_defs.vh"

// ----------------------------------------
// State
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_SQRT = 2'h1;
localparam ST_DONE = 2'h2;

reg [1:0] state_q;
reg [49:0] rem_q;
reg [24:0] root_q;
reg [51:0] rad_q;
reg [4:0] cnt_q;
reg [7:0] exp_q;
reg sign_q;

// ----------------------------------------
// Subtract datapath
// ----------------------------------------
wire [7:0] ea = op_a_in[30:23];
wire [7:0] eb = op_b_in[30:23];
wire [23:0] ma = (ea == 8'h00) ? 24'h000000 : {1'b1, op_a_in[22:0]};
wire [23:0] mb = (eb == 8'h00) ? 24'h000000 : {1'b1, op_b_in[22:0]};
wire sa = op_a_in[31];
wire sb = ~op_b_in[31];
wire a_big = {ea, ma} >= {eb, mb};
wire [7:0] e_big = a_big ? ea : eb;
wire [7:0] e_diff = a_big ? (ea - eb) : (eb - ea);
wire [26:0] m_big = {a_big ? ma : mb, 3'h0};
wire [26:0] m_sml_raw = {a_big ? mb : ma, 3'h0};
wire [26:0] m_sml = (e_diff > 8'd26) ? 27'h0 : (m_sml_raw >> e_diff);
wire s_big = a_big ? sa : sb;
wire same = (sa == sb);
wire [27:0] m_sum = same ? ({1'b0, m_big} + {1'b0, m_sml}) : ({1'b0, m_big} - {1'b0, m_sml});

reg [31:0] sub_res;
reg [27:0] norm;
reg [8:0] e_n;
integer i;
always @* begin
	norm = m_sum;
	e_n = {1'b0, e_big};
	sub_res = 32'h0;
	if (m_sum[27]) begin
		norm = m_sum >> 1;
		e_n = e_n + 9'h1;
	end else begin
		for (i = 0; i < 26; i = i + 1) begin
			if (!norm[26] && norm != 28'h0 && e_n > 9'h1) begin
				norm = norm << 1;
				e_n = e_n - 9'h1;
			end
		end
	end
	if (norm == 28'h0) begin
		sub_res = 32'h0;
	end else if (e_n >= 9'hff) begin
		sub_res = {s_big, 8'hff, 23'h0};
	end else begin
		sub_res = {s_big, e_n[7:0], norm[25:3]};
	end
end

// ----------------------------------------
// Sequencer; square root is a digit-by-digit integer root
// ----------------------------------------
wire [8:0] e_unb = {1'b0, ea} + 9'd127;
always @(posedge clock_in or negedge rstn_in) begin
	if (!rstn_in) begin
		state_q <= ST_IDLE;
		rem_q <= 50'h0;
		root_q <= 25'h0;
		rad_q <= 52'h0;
		cnt_q <= 5'h0;
		exp_q <= 8'h0;
		sign_q <= 1'b0;
		done_out <= 1'b0;
		result_out <= 32'h0;
	end else begin
		done_out <= 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (start_in && !is_sqrt_in) begin
					result_out <= sub_res;
					done_out <= 1'b1;
				end else if (start_in) begin
					sign_q <= op_a_in[31];
					exp_q <= e_unb[8:1];
					rad_q <= ea[0] ? {3'h0, ma, 25'h0} : {2'h0, ma, 26'h0};
					rem_q <= 50'h0;
					root_q <= 25'h0;
					cnt_q <= 5'h0;
					state_q <= ST_SQRT;
				end
			end
			ST_SQRT: begin
				if ({rem_q[47:0], rad_q[51:50]} >= {root_q, 2'h1}) begin
					rem_q <= {rem_q[47:0], rad_q[51:50]} - {23'h0, root_q, 2'h1};
					root_q <= {root_q[23:0], 1'b1};
				end else begin
					rem_q <= {rem_q[47:0], rad_q[51:50]};
					root_q <= {root_q[23:0], 1'b0};
				end
				rad_q <= {rad_q[49:0], 2'h0};
				cnt_q <= cnt_q + 5'h1;
				if (cnt_q == 5'd25) state_q <= ST_DONE;
			end
			ST_DONE: begin
				// A zero radicand is the only way to reach a zero root
				if (root_q == 25'h0) result_out <= 32'h0;
				else if (sign_q) result_out <= 32'h7fc00000;
				else result_out <= {1'b0, exp_q, root_q[23:1]};
				done_out <= 1'b1;
				state_q <= ST_IDLE;
			end
			default: state_q <= ST_IDLE;
		endcase
	end
end

endmodule // fpsi_fp_arith

// ---- rtl/fpsi_exec.v ----
// Executor for floating-point stack, store, arithmetic and system instructions
`timescale 1ns/1ps
module fpsi_exec #(
	parameter REG_COUNT = 32
) (
	// Clock and reset
	input wire clock_in,
	input wire rstn_in,
	// Instruction issue
	input wire issue_in,
	input wire [3:0] op_in,
	input wire cond_pass_in,
	input wire in_pred_group_in,
	input wire privileged_in,
	input wire dbl_in,
	input wire size_given_in,
	input wire [6:0] size_bits_in,
	input wire [4:0] first_reg_in,
	input wire [4:0] count_in,
	input wire [4:0] dst_reg_in,
	input wire [4:0] src_b_reg_in,
	input wire [3:0] base_idx_in,
	input wire [31:0] base_val_in,
	input wire descend_in,
	input wire wback_in,
	input wire [9:0] offset_in,
	input wire offset_neg_in,
	input wire [7:0] imm8_in,
	input wire set_form_in,
	input wire sel_pri_in,
	input wire sel_flt_in,
	input wire [3:0] flags_in,
	// Memory port
	input wire mem_ack_in,
	input wire [31:0] mem_rdata_in,
	// Status
	output reg busy_out,
	output reg done_out,
	output reg [2:0] err_out,
	output reg pc_base_out,
	output reg semihost_out,
	// Memory requests
	output reg mem_req_out,
	output reg mem_we_out,
	output reg [31:0] mem_addr_out,
	output reg [31:0] mem_wdata_out,
	// Base register writeback
	output reg base_we_out,
	output reg [3:0] base_idx_out,
	output reg [31:0] base_val_out,
	// Processor state
	output reg debug_state_out,
	output reg [7:0] breakpoint_trap_imm_out,
	output reg priority_mask_bit_out,
	output reg fault_mask_bit_out,
	output reg [3:0] flags_out,
	output reg [31:0] regfile_probe_out
);
`include "fpsi_defs.vh"

// ----------------------------------------
// State
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_XFER = 2'h1;
localparam ST_ARITH = 2'h2;

reg [1:0] state_q;
reg [31:0] xreg_q [0:REG_COUNT-1];
reg [4:0] cur_q;
reg [5:0] left_q;
reg [31:0] addr_q;
reg load_q;
reg wb_q;
reg [4:0] dst_q;
reg arith_start_q;
reg is_sqrt_q;
reg [31:0] op_a_q;
reg [31:0] op_b_q;

wire arith_done;
wire [31:0] arith_res;

fpsi_fp_arith u_arith (
	.clock_in(clock_in),
	.rstn_in(rstn_in),
	.start_in(arith_start_q),
	.is_sqrt_in(is_sqrt_q),
	.op_a_in(op_a_q),
	.op_b_in(op_b_q),
	.done_out(arith_done),
	.result_out(arith_res)
);

// ----------------------------------------
// Issue decode
// ----------------------------------------
wire is_stack = (op_in == `FPSI_OP_STACK_LOAD) || (op_in == `FPSI_OP_STACK_STORE);
wire is_multi = (op_in == `FPSI_OP_MULTI_STORE);
wire is_single = (op_in == `FPSI_OP_SINGLE_STORE);
wire [5:0] words = dbl_in ? {count_in, 1'b0} : {1'b0, count_in};
wire [5:0] single_words = dbl_in ? 6'h2 : 6'h1;
wire [31:0] list_bytes = {24'h0, words, 2'h0}; // [RL25]
wire [31:0] off32 = {22'h0, offset_in};
wire [31:0] single_addr = offset_neg_in ? base_val_in - off32 : base_val_in + off32; // [RL11]
wire [31:0] start_reg_w = dbl_in ? {26'h0, first_reg_in, 1'b0} : {27'h0, first_reg_in};
wire list_bad = (count_in == 5'h0) || (count_in > `FPSI_MAX_LIST)
	|| (start_reg_w + {26'h0, words} > REG_COUNT); // [RL3] [RL5] [RL10]
wire size_bad = size_given_in
	&& (size_bits_in != (dbl_in ? `FPSI_SIZE_DOUBLE : `FPSI_SIZE_SINGLE)); // [RL4]
wire cond_ok = cond_pass_in; // [RL22]

reg [2:0] err_d;
always @* begin
	err_d = `FPSI_ERR_NONE;
	if ((is_stack || is_multi) && list_bad) err_d = `FPSI_ERR_LIST;
	else if ((is_stack || is_multi || is_single) && size_bad) err_d = `FPSI_ERR_SIZE;
	else if (is_multi && descend_in && !wback_in) err_d = `FPSI_ERR_WBACK; // [RL9]
	else if (is_single && (offset_in[1:0] != 2'h0 || offset_in > `FPSI_MAX_OFFSET))
		err_d = `FPSI_ERR_OFFSET; // [RL11]
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
integer k;
always @(posedge clock_in or negedge rstn_in) begin
	if (!rstn_in) begin
		state_q <= ST_IDLE;
		cur_q <= 5'h0;
		left_q <= 6'h0;
		addr_q <= 32'h0;
		load_q <= 1'b0;
		wb_q <= 1'b0;
		dst_q <= 5'h0;
		arith_start_q <= 1'b0;
		is_sqrt_q <= 1'b0;
		op_a_q <= 32'h0;
		op_b_q <= 32'h0;
		busy_out <= 1'b0;
		done_out <= 1'b0;
		err_out <= `FPSI_ERR_NONE;
		pc_base_out <= 1'b0;
		semihost_out <= 1'b0;
		mem_req_out <= 1'b0;
		mem_we_out <= 1'b0;
		mem_addr_out <= 32'h0;
		mem_wdata_out <= 32'h0;
		base_we_out <= 1'b0;
		base_idx_out <= 4'h0;
		base_val_out <= 32'h0;
		debug_state_out <= 1'b0;
		breakpoint_trap_imm_out <= 8'h0;
		priority_mask_bit_out <= 1'b0;
		fault_mask_bit_out <= 1'b0;
		flags_out <= 4'h0;
		regfile_probe_out <= 32'h0;
		for (k = 0; k < REG_COUNT; k = k + 1) xreg_q[k] <= 32'h0;
	end else begin
		done_out <= 1'b0;
		base_we_out <= 1'b0;
		arith_start_q <= 1'b0;
		semihost_out <= 1'b0;
		regfile_probe_out <= xreg_q[dst_reg_in];
		case (state_q)
			ST_IDLE: begin
				if (issue_in) begin
					err_out <= `FPSI_ERR_NONE;
					pc_base_out <= 1'b0;
					if (op_in == `FPSI_OP_BREAKPOINT) begin
						// Predication is ignored; flags untouched
						debug_state_out <= 1'b1; // [RL15] [RL17] [RL18]
						breakpoint_trap_imm_out <= imm8_in; // [RL16]
						semihost_out <= (imm8_in == `FPSI_SEMIHOST_IMM); // [RL21]
						done_out <= 1'b1;
					end else if (op_in == `FPSI_OP_STATE_CHANGE) begin
						if (privileged_in) begin // [RL23]
							if (sel_pri_in) priority_mask_bit_out <= set_form_in; // [RL19] [RL20] [RL24]
							if (sel_flt_in) fault_mask_bit_out <= set_form_in; // [RL19] [RL20] [RL24]
						end
						done_out <= 1'b1;
					end else if (!cond_ok || op_in == `FPSI_OP_NONE) begin
						flags_out <= flags_in;
						done_out <= 1'b1; // [RL22]
					end else if (err_d != `FPSI_ERR_NONE) begin
						err_out <= err_d;
						done_out <= 1'b1;
					end else if (op_in == `FPSI_OP_SQUARE_ROOT || op_in == `FPSI_OP_SUBTRACT) begin
						is_sqrt_q <= (op_in == `FPSI_OP_SQUARE_ROOT); // [RL6] [RL13]
						op_a_q <= (op_in == `FPSI_OP_SQUARE_ROOT) ? xreg_q[src_b_reg_in]
							: xreg_q[first_reg_in];
						op_b_q <= xreg_q[src_b_reg_in];
						dst_q <= dst_reg_in;
						arith_start_q <= 1'b1;
						busy_out <= 1'b1;
						state_q <= ST_ARITH;
					end else begin
						cur_q <= start_reg_w[4:0]; // [RL5]
						busy_out <= 1'b1;
						base_idx_out <= is_stack ? `FPSI_SP_INDEX : base_idx_in; // [RL14]
						pc_base_out <= !is_stack && (base_idx_in == `FPSI_PC_INDEX); // [RL14]
						load_q <= (op_in == `FPSI_OP_STACK_LOAD);
						state_q <= ST_XFER;
						if (is_single) begin
							left_q <= single_words; // [RL12]
							addr_q <= single_addr;
						end else begin
							left_q <= words;
							if (op_in == `FPSI_OP_STACK_STORE || (is_multi && descend_in))
								addr_q <= base_val_in - list_bytes; // [RL2] [RL8]
							else
								addr_q <= base_val_in; // [RL1] [RL7]
						end
						if (op_in == `FPSI_OP_STACK_LOAD) base_val_out <= base_val_in + list_bytes; // [RL25]
						else if (op_in == `FPSI_OP_STACK_STORE || descend_in)
							base_val_out <= base_val_in - list_bytes; // [RL25] [RL9]
						else base_val_out <= base_val_in + list_bytes; // [RL9]
						// Latched so the end of the transfer does not depend on held inputs
						wb_q <= is_stack || (is_multi && wback_in); // [RL9] [RL25]
						mem_req_out <= 1'b0;
					end
					if (is_single) mem_we_out <= 1'b1;
					load_q <= (op_in == `FPSI_OP_STACK_LOAD);
				end
			end
			ST_XFER: begin
				if (!mem_req_out) begin
					mem_req_out <= 1'b1;
					mem_we_out <= !load_q;
					mem_addr_out <= addr_q;
					mem_wdata_out <= xreg_q[cur_q];
				end else if (mem_ack_in) begin
					mem_req_out <= 1'b0;
					if (load_q) xreg_q[cur_q] <= mem_rdata_in; // [RL1]
					cur_q <= cur_q + 5'h1;
					addr_q <= addr_q + `FPSI_WORD_BYTES;
					left_q <= left_q - 6'h1;
					if (left_q == 6'h1) begin
						busy_out <= 1'b0;
						done_out <= 1'b1;
						base_we_out <= wb_q; // [RL9] [RL25]
						state_q <= ST_IDLE;
					end
				end
			end
			ST_ARITH: begin
				if (arith_done) begin
					xreg_q[dst_q] <= arith_res; // [RL6] [RL13]
					busy_out <= 1'b0;
					done_out <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
		endcase
	end
end

endmodule // fpsi_exec

// ---- verif/fpsi_exec_props.sv ----
// Assertions on the instruction executor ports
`timescale 1ns/1ps
`include "fpsi_defs.vh"
module fpsi_exec_props (
	// Clock and reset
	input wire clock_in,
	input wire rstn_in,
	// Issue
	input wire issue_in,
	input wire [3:0] op_in,
	input wire cond_pass_in,
	input wire privileged_in,
	input wire dbl_in,
	input wire size_given_in,
	input wire [4:0] count_in,
	input wire [31:0] base_val_in,
	input wire [9:0] offset_in,
	input wire offset_neg_in,
	input wire [7:0] imm8_in,
	input wire set_form_in,
	input wire sel_pri_in,
	input wire sel_flt_in,
	input wire [3:0] flags_in,
	// Results
	input wire busy_out,
	input wire done_out,
	input wire semihost_out,
	input wire mem_req_out,
	input wire [31:0] mem_addr_out,
	input wire base_we_out,
	input wire [31:0] base_val_out,
	input wire debug_state_out,
	input wire [7:0] breakpoint_trap_imm_out,
	input wire priority_mask_bit_out,
	input wire fault_mask_bit_out,
	input wire [3:0] flags_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	wire take = issue_in && !busy_out;
	reg [3:0] op_q;
	reg [31:0] addr_q;
	reg [31:0] push_q;
	// -----------------------------
	// Addresses expected for the taken operation
	// -----------------------------
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			op_q <= 4'h0;
			addr_q <= 32'h0;
			push_q <= 32'h0;
		end else if (take) begin
			op_q <= op_in;
			addr_q <= offset_neg_in ? base_val_in - {22'h0, offset_in} : base_val_in + {22'h0, offset_in};
			push_q <= base_val_in - ({27'h0, count_in} << (dbl_in ? 3 : 2));
		end
	end
	sequence s_breakpoint_trap;
		take && op_in == `FPSI_OP_BREAKPOINT;
	endsequence
	sequence s_req_at(logic [31:0] a);
		##[1:8] (mem_req_out && mem_addr_out == a);
	endsequence
	property p_breakpoint_trap_debug;
		s_breakpoint_trap |=> debug_state_out && done_out;
	endproperty
	a_breakpoint_trap_debug: assert property (p_breakpoint_trap_debug) else $error("no debug entry");
	property p_breakpoint_trap_imm;
		s_breakpoint_trap |=> breakpoint_trap_imm_out == $past(imm8_in);
	endproperty
	a_breakpoint_trap_imm: assert property (p_breakpoint_trap_imm) else $error("immediate lost");
	property p_breakpoint_trap_flags;
		s_breakpoint_trap |=> $stable(flags_out);
	endproperty
	a_breakpoint_trap_flags: assert property (p_breakpoint_trap_flags) else $error("flags changed");
	property p_semihost;
		s_breakpoint_trap |=> semihost_out == ($past(imm8_in) == `FPSI_SEMIHOST_IMM);
	endproperty
	a_semihost: assert property (p_semihost) else $error("semihost flag wrong");
	property p_cps_pri;
		take && op_in == `FPSI_OP_STATE_CHANGE && privileged_in && sel_pri_in
			|=> priority_mask_bit_out == $past(set_form_in);
	endproperty
	a_cps_pri: assert property (p_cps_pri) else $error("priority mask wrong");
	property p_cps_flt;
		take && op_in == `FPSI_OP_STATE_CHANGE && privileged_in && sel_flt_in
			|=> fault_mask_bit_out == $past(set_form_in);
	endproperty
	a_cps_flt: assert property (p_cps_flt) else $error("fault mask wrong");
	property p_cps_unpriv;
		take && op_in == `FPSI_OP_STATE_CHANGE && !privileged_in
			|=> done_out && $stable(priority_mask_bit_out) && $stable(fault_mask_bit_out);
	endproperty
	a_cps_unpriv: assert property (p_cps_unpriv) else $error("masks changed");
	property p_skip;
		take && (op_in == `FPSI_OP_SUBTRACT || op_in == `FPSI_OP_SQUARE_ROOT) && !cond_pass_in
			|=> done_out && !mem_req_out && flags_out == $past(flags_in);
	endproperty
	a_skip: assert property (p_skip) else $error("skipped op misbehaved");
	property p_sstore_addr;
		take && op_in == `FPSI_OP_SINGLE_STORE && cond_pass_in && !size_given_in
			&& offset_in[1:0] == 2'h0 |-> s_req_at(addr_q);
	endproperty
	a_sstore_addr: assert property (p_sstore_addr) else $error("store address wrong");
	property p_push_first;
		take && op_in == `FPSI_OP_STACK_STORE && cond_pass_in && !size_given_in
			&& count_in != 5'h0 && count_in <= 5'h10 |-> s_req_at(push_q);
	endproperty
	a_push_first: assert property (p_push_first) else $error("push address wrong");
	property p_push_base;
		base_we_out && op_q == `FPSI_OP_STACK_STORE |-> base_val_out == push_q;
	endproperty
	a_push_base: assert property (p_push_base) else $error("push base wrong");
endmodule // fpsi_exec_props
bind fpsi_exec fpsi_exec_props fpsi_exec_props_i (.*);

// ---- verif/fpsi_exec_tb.sv ----
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`include "fpsi_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module fpsi_exec_tb;
	reg clock_in = 0;
	reg rstn_in = 0;
	reg issue_in, cond_pass_in, in_pred_group_in, privileged_in, dbl_in, size_given_in;
	reg descend_in, wback_in, offset_neg_in, set_form_in, sel_pri_in, sel_flt_in;
	reg [3:0] op_in, base_idx_in, flags_in;
	reg [6:0] size_bits_in;
	reg [4:0] first_reg_in, count_in, dst_reg_in, src_b_reg_in;
	reg [31:0] base_val_in;
	reg [9:0] offset_in;
	reg [7:0] imm8_in;
	reg mem_ack_in = 0;
	reg [31:0] mem_rdata_in = 0;
	wire busy_out, done_out, pc_base_out, semihost_out, mem_req_out, mem_we_out, base_we_out;
	wire debug_state_out, priority_mask_bit_out, fault_mask_bit_out;
	wire [2:0] err_out;
	wire [31:0] mem_addr_out, mem_wdata_out, base_val_out, regfile_probe_out;
	wire [3:0] base_idx_out, flags_out;
	wire [7:0] breakpoint_trap_imm_out;
	integer n_errors, tests_run;
	reg [1:0] lat = 0;
	reg [1:0] wt = 0;
	reg bwe, semi;
	reg [31:0] bval;
	logic [31:0] rd_q[$], wa[$], wd[$], we[$];
	fpsi_exec fpsi_exec_i (.*);
	always #20 clock_in = ~clock_in;
	// -----------------------------
	// Memory responder, optionally slow
	// -----------------------------
	always @(negedge clock_in) begin
		mem_ack_in <= 0;
		mem_rdata_in <= ~mem_rdata_in;
		if (mem_req_out && !mem_ack_in) begin
			if (wt < lat) wt <= wt + 1;
			else begin
				wt <= 0;
				mem_ack_in <= 1;
				mem_rdata_in <= rd_q.size() ? rd_q.pop_front() : ~mem_addr_out;
				wa.push_back(mem_addr_out);
				wd.push_back(mem_wdata_out);
				we.push_back({31'h0, mem_we_out});
			end
		end
	end
	task results;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task clr;
		begin
			{issue_in, op_in, in_pred_group_in, dbl_in, size_given_in, first_reg_in} = 0;
			{count_in, dst_reg_in, src_b_reg_in, descend_in, wback_in, offset_in} = 0;
			{offset_neg_in, imm8_in, set_form_in, sel_pri_in, sel_flt_in, flags_in} = 0;
			size_bits_in = 7'h40;
			cond_pass_in = 1;
			privileged_in = 1;
			base_idx_in = `FPSI_SP_INDEX;
			base_val_in = 32'h0;
		end
	endtask
	task run;
		integer k;
		begin
			wa.delete();
			wd.delete();
			we.delete();
			bwe = 0;
			semi = 0;
			issue_in = 1;
			k = 0;
			do begin
				@(negedge clock_in);
				issue_in = 0;
				k++;
				if (base_we_out === 1'b1) begin
					bwe = 1;
					bval = base_val_out;
				end
				semi |= semihost_out;
			end while (k < 300 && done_out !== 1'b1);
			if (done_out !== 1'b1) begin
				n_errors++;
				results;
			end
		end
	endtask
	task probe(input [4:0] r, input [31:0] e);
		begin
			dst_reg_in = r;
			@(negedge clock_in);
			@(negedge clock_in);
			`CHK("register", e, regfile_probe_out)
		end
	endtask
	task w(input integer i, input [31:0] a, input [31:0] d);
		begin
			`CHK("address", a, wa[i])
			`CHK("data", d, wd[i])
			`CHK("write enable", 1, we[i])
		end
	endtask
	task t_pop;
		integer i;
		begin
			clr;
			op_in = `FPSI_OP_STACK_LOAD;
			first_reg_in = 5'h4;
			count_in = 5'h3;
			base_val_in = 32'h2000_0100;
			lat = 2;
			run;
			lat = 0;
			`CHK("pop base", 32'h2000_010c, bval)
			`CHK("pop words", 3, wa.size())
			`CHK("pop write enable", 0, we[0])
			for (i = 0; i < 3; i++)
				probe(5'h4 + i[4:0], ~(32'h2000_0100 + 4 * i));
		end
	endtask
	task t_push;
		integer i;
		begin
			clr;
			op_in = `FPSI_OP_STACK_STORE;
			first_reg_in = 5'h4;
			count_in = 5'h3;
			base_val_in = 32'h2000_0200;
			run;
			for (i = 0; i < 3; i++)
				w(i, 32'h2000_01f4 + 4 * i, ~(32'h2000_0100 + 4 * i));
			`CHK("push base", 32'h2000_01f4, bval)
			`CHK("push base index", `FPSI_SP_INDEX, base_idx_out)
			first_reg_in = 5'h0;
			count_in = 5'h10;
			dbl_in = 1;
			run;
			`CHK("push words", 32, wa.size())
			`CHK("push base", 32'h2000_0180, bval)
		end
	endtask
	task t_mstore;
		begin
			clr;
			op_in = `FPSI_OP_MULTI_STORE;
			dbl_in = 1;
			first_reg_in = 5'h2;
			count_in = 5'h1;
			descend_in = 1;
			wback_in = 1;
			base_val_in = 32'h3000;
			run;
			w(0, 32'h2ff8, ~32'h2000_0100);
			w(1, 32'h2ffc, ~32'h2000_0104);
			`CHK("db base", 32'h2ff8, bval)
			`CHK("sp base flag", 1'b0, pc_base_out)
			clr;
			op_in = `FPSI_OP_MULTI_STORE;
			first_reg_in = 5'h4;
			count_in = 5'h2;
			base_val_in = 32'h4000;
			base_idx_in = `FPSI_PC_INDEX;
			run;
			w(0, 32'h4000, ~32'h2000_0100);
			w(1, 32'h4004, ~32'h2000_0104);
			`CHK("ia no base", 1'b0, bwe)
			`CHK("pc base flag", 1'b1, pc_base_out)
		end
	endtask
	task t_sstore;
		begin
			clr;
			op_in = `FPSI_OP_SINGLE_STORE;
			first_reg_in = 5'h5;
			offset_in = `FPSI_MAX_OFFSET;
			offset_neg_in = 1;
			base_val_in = 32'h5000;
			run;
			w(0, 32'h4c04, ~32'h2000_0104);
			dbl_in = 1;
			first_reg_in = 5'h2;
			offset_in = 10'h8;
			offset_neg_in = 0;
			run;
			w(0, 32'h5008, ~32'h2000_0100);
			w(1, 32'h500c, ~32'h2000_0104);
			cond_pass_in = 0;
			flags_in = 4'h9;
			run;
			`CHK("skip writes", 0, wa.size())
			`CHK("skip flags", 4'h9, flags_out)
		end
	endtask
	task t_err(input [3:0] op, input [4:0] n, input sg, input ds, input [9:0] of, input [2:0] e);
		begin
			clr;
			op_in = op;
			count_in = n;
			size_given_in = sg;
			descend_in = ds;
			offset_in = of;
			run;
			`CHK("error code", e, err_out)
			`CHK("error writes", 0, wa.size())
		end
	endtask
	task t_arith;
		begin
			clr;
			rd_q = '{32'h4040_0000, 32'h3f80_0000, 32'h4180_0000};
			op_in = `FPSI_OP_STACK_LOAD;
			first_reg_in = 5'h8;
			count_in = 5'h3;
			run;
			op_in = `FPSI_OP_SUBTRACT;
			src_b_reg_in = 5'h9;
			dst_reg_in = 5'hb;
			run;
			probe(5'hb, 32'h4000_0000);
			op_in = `FPSI_OP_SQUARE_ROOT;
			src_b_reg_in = 5'ha;
			dst_reg_in = 5'hc;
			run;
			probe(5'hc, 32'h4080_0000);
			op_in = `FPSI_OP_SUBTRACT;
			first_reg_in = 5'ha;
			src_b_reg_in = 5'h9;
			dst_reg_in = 5'hb;
			cond_pass_in = 0;
			run;
			probe(5'hb, 32'h4000_0000);
		end
	endtask
	task t_breakpoint_trap;
		integer i;
		reg [3:0] fb;
		begin
			for (i = 0; i < 2; i++) begin
				clr;
				op_in = `FPSI_OP_BREAKPOINT;
				cond_pass_in = 0;
				in_pred_group_in = 1;
				flags_in = 4'h6;
				imm8_in = i ? `FPSI_SEMIHOST_IMM : 8'h3c;
				fb = flags_out;
				run;
				`CHK("debug", 1'b1, debug_state_out)
				`CHK("breakpoint_trap imm", imm8_in, breakpoint_trap_imm_out)
				`CHK("semihost", i[0], semi)
				`CHK("breakpoint_trap flags", fb, flags_out)
			end
		end
	endtask
	task t_cps;
		integer i;
		reg [5:0] t [0:4];
		begin
			t = '{6'h3f, 6'h29, 6'h05, 6'h24, 6'h18};
			for (i = 0; i < 5; i++) begin
				clr;
				op_in = `FPSI_OP_STATE_CHANGE;
				{privileged_in, set_form_in, sel_pri_in, sel_flt_in} = t[i][5:2];
				run;
				`CHK("priority mask", t[i][1], priority_mask_bit_out)
				`CHK("fault mask", t[i][0], fault_mask_bit_out)
			end
		end
	endtask
	initial begin
		n_errors = 0;
		tests_run = 0;
		clr;
		repeat (12) @(negedge clock_in);
		rstn_in = 1;
		t_pop;
		t_push;
		t_mstore;
		t_sstore;
		t_err(`FPSI_OP_MULTI_STORE, 5'h0, 0, 0, 10'h0, `FPSI_ERR_LIST);
		t_err(`FPSI_OP_STACK_STORE, 5'h11, 0, 0, 10'h0, `FPSI_ERR_LIST);
		t_err(`FPSI_OP_MULTI_STORE, 5'h2, 1, 0, 10'h0, `FPSI_ERR_SIZE);
		t_err(`FPSI_OP_MULTI_STORE, 5'h1, 0, 1, 10'h0, `FPSI_ERR_WBACK);
		t_err(`FPSI_OP_SINGLE_STORE, 5'h1, 0, 0, 10'h2, `FPSI_ERR_OFFSET);
		t_arith;
		t_breakpoint_trap;
		t_cps;
		results;
	end
endmodule // fpsi_exec_tb
